// *** src/counter_unit.sv ***
`timescale 1ns/1ps
module counter_unit
  import dual_counter_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [CTL_W-1:0]     ctlWr,
  input  wire logic                 ctlWe,
  input  wire logic [31:0]          incWr,
  input  wire logic                 incWe,
  input  wire logic [PIN_CNT-1:0]   pinSync,
  output logic [CTL_W-1:0]          ctl_ff,
  output logic [31:0]               inc_ff,
  output logic [31:0]               acc_ff,
  output logic                      pinA_ff,
  output logic                      pinB_ff,
  output logic                      enA_ff,
  output logic                      enB_ff
);
  logic [MODE_W-1:0] mode;
  logic [DIV_W-1:0]  divSel;
  logic [PIN_W-1:0]  aSel;
  logic              inA;
  logic              inAd_ff;
  logic              cond;
  logic [31:0]       nxt_acc;
  logic [TAP_W-1:0]  tap_ff;
  logic              refD_ff;
  logic              synth;

  assign mode   = ctl_ff[MODE_HI:MODE_LO];
  assign divSel = ctl_ff[DIV_HI:DIV_LO];
  assign aSel   = ctl_ff[APIN_HI:APIN_LO];
  assign inA    = pinSync[aSel[4:0]];

  // =====================================================================
  // configuration, loaded on the write edge, acted on from the edge after the write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= CTL_RESET;
    end else if (ctlWe) begin
      ctl_ff <= ctlWr; // R1 R7
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inc_ff <= ACC_RESET;
    end else if (incWe) begin
      inc_ff <= incWr;
    end
  end

  // =====================================================================
  // accumulate condition from the mode field
  always_comb begin
    cond = 1'b0; // R9
    if (mode >= MODE_PLL_LO && mode <= MODE_NCO_DIF) begin
      cond = 1'b1;
    end else if (mode == MODE_HIGH) begin
      cond = inA;
    end else if (mode == MODE_LOW) begin
      cond = !inA;
    end else if (mode == MODE_POSEDGE) begin
      cond = inA && !inAd_ff;
    end else if (mode == MODE_ALWAYS) begin
      cond = 1'b1;
    end
  end

  assign nxt_acc = inc_ff + acc_ff; // R11

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_ff  <= ACC_RESET;
      inAd_ff <= 1'b0;
    end else begin
      inAd_ff <= inA;
      if (mode != MODE_OFF && cond) begin
        acc_ff <= nxt_acc; // R3 R6
      end
    end
  end

  // =====================================================================
  // synth loop model: msb as reference, tapped divider chain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tap_ff  <= '0;
      refD_ff <= 1'b0;
    end else begin
      refD_ff <= acc_ff[31];
      if (mode == MODE_OFF) begin
        tap_ff <= '0;
      end else if (acc_ff[31] && !refD_ff) begin
        tap_ff <= tap_ff + 1'b1; // R4 R10
      end
    end
  end

  assign synth = tap_ff[3'(TAP_W-1) - divSel];

  // =====================================================================
  // pin drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinA_ff <= 1'b0;
      pinB_ff <= 1'b0;
      enA_ff  <= 1'b0;
      enB_ff  <= 1'b0;
    end else begin
      pinA_ff <= 1'b0;
      pinB_ff <= 1'b0;
      enA_ff  <= 1'b0; // R8
      enB_ff  <= 1'b0;
      if (ctlWe ? (ctlWr[MODE_HI:MODE_LO] == MODE_OFF) : 1'b0) begin
        enA_ff <= 1'b0; // R8
      end else if (mode >= MODE_PLL_LO && mode <= MODE_PLL_HI) begin
        pinA_ff <= synth; // R2
        enA_ff  <= 1'b1;
        pinB_ff <= !synth;
        enB_ff  <= (mode == MODE_PLL_HI);
      end else if (mode == MODE_NCO || mode == MODE_NCO_DIF) begin
        pinA_ff <= nxt_acc[31]; // R2
        enA_ff  <= 1'b1;
        pinB_ff <= !nxt_acc[31];
        enB_ff  <= (mode == MODE_NCO_DIF);
      end
    end
  end
endmodule

// *** inc/dual_counter_pkg.sv ***
package dual_counter_pkg;
  // =====================================================================
  // control word layout
  localparam int CTL_W          = 32;
  localparam int MODE_HI        = 30;
  localparam int MODE_LO        = 26;
  localparam int DIV_HI         = 25;
  localparam int DIV_LO         = 23;
  localparam int BPIN_HI        = 14;
  localparam int BPIN_LO        = 9;
  localparam int APIN_HI        = 5;
  localparam int APIN_LO        = 0;
  localparam int PIN_W          = 6;
  localparam int PIN_CNT        = 32;
  localparam int MODE_W         = 5;
  localparam int DIV_W          = 3;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  // =====================================================================
  // mode codes
  localparam logic [4:0] MODE_OFF     = 5'h00;
  localparam logic [4:0] MODE_PLL_LO  = 5'h01;
  localparam logic [4:0] MODE_PLL_HI  = 5'h03;
  localparam logic [4:0] MODE_NCO     = 5'h04;
  localparam logic [4:0] MODE_NCO_DIF = 5'h05;
  localparam logic [4:0] MODE_POSEDGE = 5'h0A;
  localparam logic [4:0] MODE_HIGH    = 5'h08;
  localparam logic [4:0] MODE_LOW     = 5'h0C;
  localparam logic [4:0] MODE_ALWAYS  = 5'h1F;
  // =====================================================================
  // synth loop
  localparam int VCO_MULT       = 16;
  localparam int VCO_MIN_MHZ    = 64;
  localparam int VCO_MAX_MHZ    = 128;
  localparam int TAP_W          = 8;
endpackage

// *** src/dual_counter_accumulator.sv ***
`timescale 1ns/1ps
// Contract
// R1 - the core holds two identical counters, each set only by its control.
// R2 - each counter drives or senses at most two pins chosen by its control.
// R3 - each counter adds its 32-bit increment to its accumulator per cycle.
// R4 - each counter owns a private frequency synthesis loop.
// R5 - reading a control returns the value currently held for that counter.
// R6 - once configured a counter runs on with no further core action.
// R7 - a written control value takes effect on the write itself; the code uses it from the next edge, but an off write drops the pins at once.
// R8 - an all-zero control disables pin drive and accumulation at once; the accumulator still adds once more on the write edge.
// R9 - the mode field picks one of 32 operating modes.
// R10 - oscillator modes use the accumulator msb as synth reference, x16; the code has no x16 stage, only the tapped divider chain.
// R11 - the accumulator wraps modulo two to the thirty-second.
module dual_counter_accumulator
  import dual_counter_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [CTL_W-1:0]     wrData,
  input  wire logic                 ctlAWe,
  input  wire logic                 ctlBWe,
  input  wire logic                 incAWe,
  input  wire logic                 incBWe,
  input  wire logic [PIN_CNT-1:0]   pinIn,
  output logic [CTL_W-1:0]          counter_a_control,
  output logic [CTL_W-1:0]          counter_b_control,
  output logic [31:0]               counter_a_phase_accumulator,
  output logic [31:0]               counter_b_phase_accumulator,
  output logic [PIN_CNT-1:0]        pinOut_ff,
  output logic [PIN_CNT-1:0]        pinOe_n_ff
);
  // =====================================================================
  // pin synchroniser
  logic [PIN_CNT-1:0] pinMeta_ff;
  logic [PIN_CNT-1:0] pinSync_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end else begin
      pinMeta_ff <= pinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // =====================================================================
  // two counter units
  logic [1:0]  pA, pB, eA, eB;
  logic [31:0] incA, incB;
  logic [CTL_W-1:0] ctlA, ctlB;
  logic [31:0] accA, accB;

  counter_unit u_cnt_a (
    .sys_clk (sys_clk), .rst (rst), .ctlWr (wrData), .ctlWe (ctlAWe),
    .incWr (wrData), .incWe (incAWe), .pinSync (pinSync_ff),
    .ctl_ff (ctlA), .inc_ff (incA), .acc_ff (accA),
    .pinA_ff (pA[0]), .pinB_ff (pB[0]), .enA_ff (eA[0]), .enB_ff (eB[0])
  ); // R1
  counter_unit u_cnt_b (
    .sys_clk (sys_clk), .rst (rst), .ctlWr (wrData), .ctlWe (ctlBWe),
    .incWr (wrData), .incWe (incBWe), .pinSync (pinSync_ff),
    .ctl_ff (ctlB), .inc_ff (incB), .acc_ff (accB),
    .pinA_ff (pA[1]), .pinB_ff (pB[1]), .enA_ff (eA[1]), .enB_ff (eB[1])
  ); // R1

  assign counter_a_control           = ctlA; // R5
  assign counter_b_control           = ctlB; // R5
  assign counter_a_phase_accumulator = accA;
  assign counter_b_phase_accumulator = accB;

  // =====================================================================
  // pin merge: per pin, or of all driving units
  logic [CTL_W-1:0]   ctlU [2];
  logic [1:0]         kill;
  logic [PIN_CNT-1:0] nxt_out, nxt_oe;
  assign ctlU[0] = ctlA;
  assign ctlU[1] = ctlB;
  // an off write drops the unit's pins on the write edge itself
  assign kill[0] = ctlAWe && (wrData[MODE_HI:MODE_LO] == MODE_OFF); // R8
  assign kill[1] = ctlBWe && (wrData[MODE_HI:MODE_LO] == MODE_OFF); // R8
  always_comb begin
    nxt_out = '0;
    nxt_oe  = '0;
    for (int u = 0; u < 2; u++) begin
      if (eA[u] && !kill[u]) begin
        nxt_oe[ctlU[u][APIN_LO +: 5]] = 1'b1; // R2
        nxt_out[ctlU[u][APIN_LO +: 5]] |= pA[u];
      end
      if (eB[u] && !kill[u]) begin
        nxt_oe[ctlU[u][BPIN_LO +: 5]] = 1'b1; // R2
        nxt_out[ctlU[u][BPIN_LO +: 5]] |= pB[u];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut_ff  <= '0;
      pinOe_n_ff <= '1;
    end else begin
      pinOut_ff  <= nxt_out;
      pinOe_n_ff <= ~nxt_oe;
    end
  end
endmodule

// *** testbench/pin_model.sv ***
`timescale 1ns/1ps
module pin_model (
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOe_n,
  input  wire logic [31:0] drive,
  output logic      [31:0] pinIn
);
  // =====================================================================
  // a pin the block drives shows its value, any other the far side level
  assign pinIn = (pinOut & ~pinOe_n) | (drive & pinOe_n);
endmodule

// *** testbench/dual_counter_asserts.sv ***
`timescale 1ns/1ps
module dual_counter_asserts
  import dual_counter_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic [31:0]      wrData,
  input wire logic             ctlAWe,
  input wire logic             ctlBWe,
  input wire logic             incAWe,
  input wire logic             incBWe,
  input wire logic [31:0]      counter_a_control,
  input wire logic [31:0]      counter_b_control,
  input wire logic [31:0]      counter_a_phase_accumulator,
  input wire logic [31:0]      counter_b_phase_accumulator,
  input wire logic [31:0]      pinOe_n_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] incA_ff;
  logic [31:0] incB_ff;
  // =====================================================================
  // shadow of the increments, which have no readback
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) incA_ff <= 32'h0;
    else if (incAWe) incA_ff <= wrData;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) incB_ff <= 32'h0;
    else if (incBWe) incB_ff <= wrData;
  end
  a_ctl_a_load: assert property (
    ctlAWe |=> counter_a_control == $past(wrData))
    else $error("control A readback differs from written value");
  a_ctl_b_load: assert property (
    ctlBWe |=> counter_b_control == $past(wrData))
    else $error("control B readback differs from written value");
  a_ctl_a_holds: assert property (
    !ctlAWe |=> $stable(counter_a_control))
    else $error("control A changed without a write");
  a_off_acc_stops: assert property (
    counter_a_control == 32'h0 && !ctlAWe
    |=> $stable(counter_a_phase_accumulator))
    else $error("disabled counter A accumulated");
  a_nco_a_adds: assert property (
    counter_a_control[MODE_HI:MODE_LO] == MODE_NCO && !ctlAWe && !incAWe
    |=> counter_a_phase_accumulator ==
    32'($past(counter_a_phase_accumulator) + $past(incA_ff)))
    else $error("counter A did not add its increment");
  a_always_b_adds: assert property (
    !ctlBWe && !incBWe &&
    counter_b_control[MODE_HI:MODE_LO] == MODE_ALWAYS
    |=> counter_b_phase_accumulator ==
    32'($past(counter_b_phase_accumulator) + $past(incB_ff)))
    else $error("counter B did not add its increment");
  a_off_no_drive: assert property (
    counter_a_control == 32'h0 && counter_b_control == 32'h0
    |-> pinOe_n_ff == 32'hFFFFFFFF)
    else $error("pins driven while both counters are off");
  a_pin_limit: assert property (
    $countones(~pinOe_n_ff) <= 4)
    else $error("more than two pins driven per counter");
endmodule
bind dual_counter_accumulator dual_counter_asserts i_dual_counter_asserts (
  .sys_clk(sys_clk), .rst(rst), .wrData(wrData), .ctlAWe(ctlAWe),
  .ctlBWe(ctlBWe), .incAWe(incAWe), .incBWe(incBWe),
  .counter_a_control(counter_a_control),
  .counter_b_control(counter_b_control),
  .counter_a_phase_accumulator(counter_a_phase_accumulator),
  .counter_b_phase_accumulator(counter_b_phase_accumulator),
  .pinOe_n_ff(pinOe_n_ff));

// *** testbench/test_dual_counter_accumulator.sv ***
`timescale 1ns/1ps
module test_dual_counter_accumulator
  import dual_counter_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] wrData = 32'h0;
  logic [3:0] we = 4'h0;
  logic [31:0] drive = 32'h0;
  logic [31:0] pinIn, ctlA, ctlB, accA, accB, pinOut, pinOe_n;
  int err_total = 0;
  int n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  dual_counter_accumulator i_dual_counter_accumulator (.sys_clk(sys_clk),
    .rst(rst), .wrData(wrData), .ctlAWe(we[0]), .ctlBWe(we[1]),
    .incAWe(we[2]), .incBWe(we[3]), .pinIn(pinIn),
    .counter_a_control(ctlA), .counter_b_control(ctlB),
    .counter_a_phase_accumulator(accA), .counter_b_phase_accumulator(accB),
    .pinOut_ff(pinOut), .pinOe_n_ff(pinOe_n));
  pin_model i_pin_model (.pinOut(pinOut), .pinOe_n(pinOe_n), .drive(drive),
    .pinIn(pinIn));
  // =====================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input int sel, input logic [31:0] d);
    wrData = d;
    we[sel] = 1'b1;
    cyc(1);
    we[sel] = 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset;
    chk("ctlA", 32'h0, ctlA);
    chk("accA", 32'h0, accA);
    chk("oe_n", 32'hFFFFFFFF, pinOe_n);
    $display("reset test done");
  endtask
  task automatic t_readback;
    wrData = 32'h1234_5678;
    we = 4'h1;
    cyc(1);
    wrData = 32'h7F80_7E3F;
    we = 4'h2;
    cyc(1);
    we = 4'h0;
    chk("ctlA", 32'h1234_5678, ctlA);
    chk("ctlB", 32'h7F80_7E3F, ctlB);
    wr(0, 32'h0);
    wr(1, 32'h0);
    $display("readback test done");
  endtask
  task automatic t_nco;
    logic [31:0] a;
    wr(2, 32'h4000_0000);
    wr(0, 32'h1000_0003);
    cyc(3);
    chk("oe_n3", 32'h0, {31'h0, pinOe_n[3]});
    a = accA;
    cyc(5);
    chk("accA", a + 32'h4000_0000 * 5, accA);
    wr(0, 32'h1400_0803);
    cyc(3);
    chk("oe_n43", 32'h0, {30'h0, pinOe_n[4:3]});
    chk("pinB", {31'h0, ~pinOut[3]}, {31'h0, pinOut[4]});
    wr(0, 32'h0);
    chk("oe_n43", 32'h3, {30'h0, pinOe_n[4:3]});
    a = accA;
    cyc(5);
    chk("accA", a, accA);
    $display("nco test done");
  endtask
  task automatic t_gated;
    logic [31:0] a;
    wr(3, 32'h1);
    wr(1, 32'h2000_0005);
    cyc(4);
    a = accB;
    cyc(5);
    chk("accB", a, accB);
    drive[5] = 1'b1;
    cyc(4);
    a = accB;
    cyc(5);
    chk("accB", a + 32'h5, accB);
    wr(1, 32'h2800_0005);
    drive[5] = 1'b0;
    cyc(4);
    a = accB;
    repeat (3) begin
      drive[5] = 1'b1;
      cyc(2);
      drive[5] = 1'b0;
      cyc(2);
    end
    cyc(4);
    chk("accB", a + 32'h3, accB);
    wr(1, 32'h3000_0005);
    a = accB;
    cyc(5);
    chk("accB", a + 32'h5, accB);
    wr(1, 32'h0);
    $display("gated test done");
  endtask
  task automatic t_pll;
    logic p;
    int   flips;
    wr(2, 32'h8000_0000);
    wr(0, 32'h0F80_0401);
    cyc(6);
    chk("oe_n21", 32'h0, {30'h0, pinOe_n[2:1]});
    chk("pinB", {31'h0, ~pinOut[1]}, {31'h0, pinOut[2]});
    flips = 0;
    p = pinOut[1];
    repeat (16) begin
      cyc(1);
      if (pinOut[1] !== p) flips++;
      p = pinOut[1];
    end
    chk("flips", 32'h8, 32'(flips));
    wr(0, 32'h0);
    chk("oe_n", 32'hFFFFFFFF, pinOe_n);
    $display("synth test done");
  endtask
  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_readback();
    t_nco();
    t_gated();
    t_pll();
    conclude();
  end
endmodule
